// ==== logic/rdsm_defines.svh ====
// Offsets, field positions and timing counts for the device state controller
`ifndef RDSM_DEFINES_SVH
`define RDSM_DEFINES_SVH

// Register byte addresses
`define RDSM_CTRL_ADDR      12'h000
`define RDSM_OVR_ADDR       12'h004
`define RDSM_STAT_ADDR      12'h008
`define RDSM_FLAG_ADDR      12'h00C

// Control register fields
`define RDSM_CTRL_EXC_EN    0
`define RDSM_CTRL_LOOP_EN   1
`define RDSM_CTRL_RERUN     2
`define RDSM_CTRL_LEAVE     3

// Override register fields
`define RDSM_OVR_EXCUV      0
`define RDSM_OVR_INPUT      1
`define RDSM_OVR_SELFTEST   2
`define RDSM_OVR_READBACK   3

// Status register fields
`define RDSM_STAT_STATE_LO  0
`define RDSM_STAT_MON_EN    2
`define RDSM_STAT_DIAG_DONE 3
`define RDSM_STAT_DIAG_FLT  4

// Timing: clock period in ns and deglitch time in ns
`define RDSM_CLK_PERIOD_NS  50
`define RDSM_DEGLITCH_NS    70000
`define RDSM_DEGLITCH_CYC   ((`RDSM_DEGLITCH_NS + `RDSM_CLK_PERIOD_NS - 1) / `RDSM_CLK_PERIOD_NS)

`endif

// ==== logic/rdsm_pkg.sv ====
// Types shared by the device state controller
package rdsm_pkg;

    typedef enum logic [1:0] {
        RDSM_RESET  = 2'b00,
        RDSM_DIAG   = 2'b01,
        RDSM_NORMAL = 2'b10,
        RDSM_FAULT  = 2'b11
    } rdsm_state_e;

    // Fault inputs from the detectors, grouped by exciter handling
    typedef struct packed {
        logic offset_cal_fault;
        logic core_reg_overcurrent;
        logic thermal_warning_fault;
        logic user_nvm_crc_fault;
        logic trim_nvm_crc_fault;
        logic serial_comm_fault;
        logic exc_undervolt_fault;
        logic input_fault;
        logic tracking_input_error;
        logic analog_selftest_fault;
        logic logic_selftest_fault;
        logic fault_pin_readback_error;
        logic other_fault;
    } rdsm_faults_s;

    // Conditions that force internal reset
    typedef struct packed {
        logic supply_uv;
        logic core_uv;
        logic clock_loss;
        logic thermal_shutdown;
    } rdsm_reset_src_s;

    // Enables driven to the functional blocks
    typedef struct packed {
        logic boost;
        logic core_reg;
        logic exciter;
        logic loop;
        logic monitor;
        logic front_end;
        logic data_valid;
    } rdsm_enables_s;

endpackage

// ==== logic/rdsm_state_ctrl.sv ====
// Operating-state controller of a resolver-to-digital converter
//
// Behaviour
// (RULE1) Reset disables all blocks, fault pin low
// (RULE2) Supply, core, clock, thermal faults force reset
// (RULE3) Leave reset when cleared and pin high
// (RULE4) Start in diagnostics after reset release
// (RULE5) Diagnostics: regulators on, others off, pin low; front-end enable stays on
// (RULE6) Diagnostics runs CRC, self-tests, offset calibration
// (RULE7) Clean checks go normal, faults lock diagnostics
// (RULE8) Force-leave bit exits locked diagnostics
// (RULE9) Rerun bit returns normal to diagnostics; self-clear
// (RULE10) Commanded diagnostics disables exciter and loop
// (RULE11) Normal enables exciter, loop, then monitor
// (RULE12) Enable bits read back and control blocks
// (RULE13) Normal with all enabled gives valid data
// (RULE14) Fault in normal enters fault, pin released
// (RULE15) Fault state disables loop, freezes output data
// (RULE16) Listed faults keep exciter enabled
// (RULE17) Exciter undervoltage disables exciter unless overridden
// (RULE18) Input faults disable exciter unless overridden
// (RULE19) Self-test, readback faults obey their overrides
// (RULE20) Other faults block exciter until back normal
// (RULE21) Fault-clear pulse returns device to normal
// (RULE22) Host limits fault-clear pulse width and rate
// (RULE23) Reset pin release deglitched for 70 us
// (RULE24) Operating state readable from status register
// (RULE25) Fault-clear pin synchronised, acts on rising edge
`timescale 1ns/1ps
`include "rdsm_defines.svh"

module rdsm_state_ctrl #(
    parameter int DEGLITCH_CYC = `RDSM_DEGLITCH_CYC
) (
    // Clock and reset
    input  wire logic                     CLK,
    input  wire logic                     RST,
    // Control pins
    input  wire logic                     RESET_PIN_ACTIVE_LOW_N,
    input  wire logic                     FAULT_CLEAR_PIN,
    // Fault pin, open drain
    input  wire logic                     FAULT_PIN_IN,
    output logic                          FAULT_PIN_OUT,
    output logic                          FAULT_PIN_OE,
    // Detector inputs
    input  wire rdsm_pkg::rdsm_reset_src_s RESET_SRC,
    input  wire rdsm_pkg::rdsm_faults_s   FAULTS,
    // Self-check handshake
    output logic                          CHECK_START,
    input  wire logic                     CHECK_DONE,
    input  wire logic                     CHECK_FAULT,
    // Block enables
    output rdsm_pkg::rdsm_enables_s       ENABLES,
    output logic                          INTERNAL_POWER_ON_RESET_N,
    // APB slave
    input  wire logic                     PSEL,
    input  wire logic                     PENABLE,
    input  wire logic                     PWRITE,
    input  wire logic [11:0]              PADDR,
    input  wire logic [31:0]              PWDATA,
    output logic [31:0]                   PRDATA,
    output logic                          PREADY,
    output logic                          PSLVERR
);
    import rdsm_pkg::*;

    rdsm_state_e state_q;
    logic [2:0]  rst_sync_q;
    logic [2:0]  fclr_sync_q;
    logic        fclr_lvl_q;
    logic [31:0] deglitch_q;
    logic        por_n_q;
    logic        exc_en_q;
    logic        loop_en_q;
    logic        mon_en_q;
    logic        rerun_q;
    logic        leave_q;
    logic [3:0]  ovr_q;
    logic        diag_done_q;
    logic        diag_flt_q;
    logic        check_start_q;
    logic        exc_block_q;
    logic        fault_pin_q;
    logic        fault_oe_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [1:0]  seq_q;

    logic reset_cond;
    logic rst_pin_hi;
    logic fclr_rise;
    logic any_fault;
    logic exc_kill;
    logic apb_wr;
    logic apb_rd;
    logic wr_ctrl;
    logic wr_ovr;

    // Internal reset conditions
    assign reset_cond = |RESET_SRC; // see (RULE2)
    assign any_fault  = |FAULTS;

    // Faults whose handling turns the exciter off
    assign exc_kill = (FAULTS.exc_undervolt_fault && !ovr_q[`RDSM_OVR_EXCUV])       // see (RULE17)
                   || ((FAULTS.input_fault || FAULTS.tracking_input_error)
                       && !ovr_q[`RDSM_OVR_INPUT])                                  // see (RULE18)
                   || ((FAULTS.analog_selftest_fault || FAULTS.logic_selftest_fault)
                       && !ovr_q[`RDSM_OVR_SELFTEST])                               // see (RULE19)
                   || (FAULTS.fault_pin_readback_error && !ovr_q[`RDSM_OVR_READBACK])
                   || FAULTS.other_fault;                                           // see (RULE20)

    // Pin synchronisers: fault-clear level changes once stages two and three agree, reset pin reads high only when both are high
    always_ff @(posedge CLK) begin
        if (RST) begin
            rst_sync_q  <= 3'h0;
            fclr_sync_q <= 3'h7;
        end else begin
            rst_sync_q  <= {rst_sync_q[1:0], RESET_PIN_ACTIVE_LOW_N};
            fclr_sync_q <= {fclr_sync_q[1:0], FAULT_CLEAR_PIN};
        end
    end

    assign rst_pin_hi = rst_sync_q[1] && rst_sync_q[2];

    always_ff @(posedge CLK) begin
        if (RST) begin
            fclr_lvl_q <= 1'b1;
        end else if (fclr_sync_q[1] == fclr_sync_q[2]) begin
            fclr_lvl_q <= fclr_sync_q[2];
        end
    end

    // Fault-clear acts on the rising edge closing a high-low-high pulse
    assign fclr_rise = (fclr_sync_q[1] && fclr_sync_q[2]) && !fclr_lvl_q; // see (RULE25)

    // Internal power-on reset with release deglitch
    always_ff @(posedge CLK) begin
        if (RST) begin
            deglitch_q <= 32'h0;
            por_n_q    <= 1'b0;
        end else if (reset_cond || !rst_pin_hi) begin
            deglitch_q <= 32'h0;
            por_n_q    <= 1'b0;
        end else if (deglitch_q < DEGLITCH_CYC - 1) begin
            deglitch_q <= deglitch_q + 32'h1; // see (RULE23)
        end else begin
            por_n_q <= 1'b1; // see (RULE3)
        end
    end

    // APB decode, access phase with one wait state
    assign apb_wr  = PSEL && PENABLE && PWRITE && !pready_q;
    assign apb_rd  = PSEL && PENABLE && !PWRITE && !pready_q;
    assign wr_ctrl = apb_wr && (PADDR == `RDSM_CTRL_ADDR);
    assign wr_ovr  = apb_wr && (PADDR == `RDSM_OVR_ADDR);

    // Operating state
    always_ff @(posedge CLK) begin
        if (RST || !por_n_q) begin
            state_q <= RDSM_RESET; // see (RULE1)
        end else begin
            case (state_q)
                RDSM_RESET: state_q <= RDSM_DIAG; // see (RULE4)
                RDSM_DIAG: begin
                    if (leave_q && diag_flt_q) begin
                        state_q <= RDSM_NORMAL; // see (RULE8)
                    end else if (diag_done_q && !diag_flt_q) begin
                        state_q <= RDSM_NORMAL; // see (RULE7)
                    end
                end
                RDSM_NORMAL: begin
                    if (rerun_q) begin
                        state_q <= RDSM_DIAG; // see (RULE9)
                    end else if (any_fault) begin
                        state_q <= RDSM_FAULT; // see (RULE14)
                    end
                end
                RDSM_FAULT: begin
                    if (fclr_rise) begin
                        state_q <= RDSM_NORMAL; // see (RULE21)
                    end
                end
                default: state_q <= RDSM_RESET;
            endcase
        end
    end

    // Self-check run: start pulse on entry, result latched
    always_ff @(posedge CLK) begin
        if (RST || !por_n_q) begin
            check_start_q <= 1'b0;
            diag_done_q   <= 1'b0;
            diag_flt_q    <= 1'b0;
        end else begin
            check_start_q <= (state_q != RDSM_DIAG) && (state_q != RDSM_FAULT)
                             && ((state_q == RDSM_RESET) || rerun_q); // see (RULE6)
            if (state_q != RDSM_DIAG) begin
                diag_done_q <= 1'b0;
                diag_flt_q  <= 1'b0;
            end else if (CHECK_DONE && !diag_done_q) begin
                diag_done_q <= 1'b1;
                diag_flt_q  <= CHECK_FAULT; // see (RULE7)
            end
        end
    end

    // Self-clearing command bits; a write sets, completion clears
    always_ff @(posedge CLK) begin
        if (RST || !por_n_q) begin
            rerun_q <= 1'b0;
            leave_q <= 1'b0;
        end else begin
            if (wr_ctrl && PWDATA[`RDSM_CTRL_RERUN] && state_q == RDSM_NORMAL) begin
                rerun_q <= 1'b1;
            end else if (state_q == RDSM_DIAG) begin
                rerun_q <= 1'b0; // see (RULE9)
            end
            if (wr_ctrl && PWDATA[`RDSM_CTRL_LEAVE] && state_q == RDSM_DIAG) begin
                leave_q <= 1'b1;
            end else if (state_q == RDSM_NORMAL) begin
                leave_q <= 1'b0; // see (RULE8)
            end
        end
    end

    // Override bits
    always_ff @(posedge CLK) begin
        if (RST || !por_n_q) begin
            ovr_q <= 4'h0;
        end else if (wr_ovr) begin
            ovr_q <= PWDATA[3:0];
        end
    end

    // Exciter blocked by severe faults until normal is reached again
    always_ff @(posedge CLK) begin
        if (RST || !por_n_q) begin
            exc_block_q <= 1'b0;
        end else if (FAULTS.other_fault) begin
            exc_block_q <= 1'b1; // see (RULE20)
        end else if (state_q == RDSM_NORMAL && !any_fault) begin
            exc_block_q <= 1'b0;
        end
    end

    // Enable sequence: exciter, then loop, then monitor
    always_ff @(posedge CLK) begin
        if (RST || !por_n_q || state_q == RDSM_DIAG) begin
            exc_en_q  <= 1'b0; // see (RULE5) (RULE10)
            loop_en_q <= 1'b0;
            mon_en_q  <= 1'b0;
            seq_q     <= 2'h0;
        end else if (state_q == RDSM_FAULT || (state_q == RDSM_NORMAL && any_fault)) begin
            loop_en_q <= 1'b0; // see (RULE15)
            if (exc_kill || exc_block_q) begin
                exc_en_q <= 1'b0; // see (RULE16)
            end
            seq_q <= 2'h0;
        end else if (state_q == RDSM_NORMAL) begin
            if (seq_q != 2'h3) begin
                seq_q <= seq_q + 2'h1;
            end
            if (seq_q == 2'h0) begin
                exc_en_q <= 1'b1; // see (RULE11)
            end
            if (seq_q == 2'h1) begin
                loop_en_q <= 1'b1;
            end
            if (seq_q == 2'h2) begin
                mon_en_q <= 1'b1;
            end
            if (wr_ctrl && seq_q == 2'h3) begin
                exc_en_q  <= PWDATA[`RDSM_CTRL_EXC_EN] && !exc_block_q; // see (RULE12)
                loop_en_q <= PWDATA[`RDSM_CTRL_LOOP_EN];
            end
        end
    end

    // Fault pin: low in reset, diagnostics and normal, released in fault
    always_ff @(posedge CLK) begin
        if (RST || !por_n_q) begin
            fault_pin_q <= 1'b0;
            fault_oe_q  <= 1'b1; // see (RULE1)
        end else begin
            fault_pin_q <= 1'b0;
            fault_oe_q  <= !(state_q == RDSM_FAULT); // see (RULE14) (RULE5) (RULE13)
        end
    end

    // Enables and data valid
    always_ff @(posedge CLK) begin
        if (RST || !por_n_q) begin
            ENABLES <= '0; // see (RULE1)
        end else begin
            ENABLES.boost      <= 1'b1; // see (RULE5)
            ENABLES.core_reg   <= 1'b1;
            ENABLES.front_end  <= 1'b1;
            ENABLES.exciter    <= exc_en_q;
            ENABLES.loop       <= loop_en_q;
            ENABLES.monitor    <= mon_en_q;
            ENABLES.data_valid <= (state_q == RDSM_NORMAL) && exc_en_q && loop_en_q
                                  && mon_en_q; // see (RULE13) (RULE15)
        end
    end

    // APB read data and ready
    always_ff @(posedge CLK) begin
        if (RST) begin
            prdata_q  <= 32'h0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= PSEL && PENABLE && !pready_q;
            pslverr_q <= 1'b0;
            if (apb_rd) begin
                case (PADDR)
                    `RDSM_CTRL_ADDR: prdata_q <= {28'h0, leave_q, rerun_q, loop_en_q, exc_en_q};
                    `RDSM_OVR_ADDR:  prdata_q <= {28'h0, ovr_q};
                    `RDSM_STAT_ADDR: prdata_q <= {27'h0, diag_flt_q, diag_done_q, mon_en_q,
                                                  state_q}; // see (RULE24)
                    `RDSM_FLAG_ADDR: prdata_q <= {19'h0, FAULTS};
                    default: begin
                        prdata_q  <= 32'h0;
                        pslverr_q <= 1'b1;
                    end
                endcase
            end else if (PSEL && PENABLE && !pready_q) begin
                prdata_q  <= 32'h0;
                pslverr_q <= !((PADDR == `RDSM_CTRL_ADDR) || (PADDR == `RDSM_OVR_ADDR));
            end
        end
    end

    assign FAULT_PIN_OUT             = fault_pin_q;
    assign FAULT_PIN_OE              = fault_oe_q;
    assign CHECK_START               = check_start_q;
    assign INTERNAL_POWER_ON_RESET_N = por_n_q;
    assign PRDATA                    = prdata_q;
    assign PREADY                    = pready_q;
    assign PSLVERR                   = pslverr_q;

    // Checks
    chk_fault_pin_rel: assert property (@(posedge CLK) disable iff (RST) // see (RULE14)
        (por_n_q && state_q == RDSM_FAULT) |=> !FAULT_PIN_OE)
        else $error("fault pin not released in fault state");
    chk_reset_blocks_off: assert property (@(posedge CLK) disable iff (RST) // see (RULE1)
        !por_n_q |=> (ENABLES == '0 && FAULT_PIN_OE))
        else $error("blocks enabled during reset");
    chk_reset_source: assert property (@(posedge CLK) disable iff (RST) // see (RULE2)
        reset_cond |=> !por_n_q)
        else $error("reset condition did not reset logic");
    chk_diag_exciter_off: assert property (@(posedge CLK) disable iff (RST) // see (RULE5)
        (por_n_q && state_q == RDSM_DIAG) |=> ##1 (!ENABLES.exciter || state_q != RDSM_DIAG))
        else $error("exciter on in diagnostics");
    chk_after_reset_diag: assert property (@(posedge CLK) disable iff (RST) // see (RULE4)
        $rose(por_n_q) |=> state_q == RDSM_DIAG)
        else $error("did not start in diagnostics");
    chk_seq_order: assert property (@(posedge CLK) disable iff (RST) // see (RULE11)
        $rose(mon_en_q) |-> (exc_en_q || exc_block_q) && loop_en_q)
        else $error("monitor enabled out of order");
    chk_fault_loop_off: assert property (@(posedge CLK) disable iff (RST) // see (RULE15)
        (por_n_q && state_q == RDSM_FAULT) |=> !loop_en_q)
        else $error("loop enabled in fault state");
    chk_exc_undervolt: assert property (@(posedge CLK) disable iff (RST) // see (RULE17)
        (por_n_q && state_q == RDSM_FAULT && FAULTS.exc_undervolt_fault
         && !ovr_q[`RDSM_OVR_EXCUV]) |=> !exc_en_q)
        else $error("exciter kept on after undervoltage");
    chk_rerun_clear: assert property (@(posedge CLK) disable iff (RST) // see (RULE9)
        (rerun_q && state_q == RDSM_DIAG) |=> !rerun_q)
        else $error("rerun bit not self-cleared");
    chk_data_valid: assert property (@(posedge CLK) disable iff (RST) // see (RULE13)
        ENABLES.data_valid |-> $past(state_q) == RDSM_NORMAL)
        else $error("data valid outside normal");
endmodule

// ==== tb/rdsm_check_model.sv ====
// Self-check engine model that answers each of the controller's check requests, at start-up and on rerun
`timescale 1ns/1ps
module rdsm_check_model (
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       RST,
    // Behaviour chosen by the bench
    input  wire logic [7:0] DELAY,
    input  wire logic       FAIL,
    // Check handshake
    input  wire logic       CHECK_START,
    output logic            CHECK_DONE,
    output logic            CHECK_FAULT
);
    int unsigned left;

    // CRC, both self-tests and offset calibration run as one timed job
    always @(posedge CLK) begin
        CHECK_DONE <= 1'b0;
        if (RST) begin
            left        <= 0;
            CHECK_FAULT <= 1'b0;
        end else if (CHECK_START) begin
            left        <= DELAY + 1;
            // Result is not valid while busy, so show the wrong one
            CHECK_FAULT <= ~FAIL;
        end else if (left == 1) begin
            left        <= 0;
            CHECK_DONE  <= 1'b1;
            CHECK_FAULT <= FAIL;
        end else if (left != 0) begin
            left <= left - 1;
        end
    end
endmodule

// ==== tb/resolver_device_state_machine_bench.sv ====
// Self-checking bench for the operating-state controller
`timescale 1ns/1ps
`include "rdsm_defines.svh"
module resolver_device_state_machine_bench;
    import rdsm_pkg::*;
    localparam int DEGLITCH = 4;
    logic            clk = 1'b0;
    logic            rst;
    logic            reset_pin_n;
    logic            fault_clear;
    logic            fault_pin_in;
    logic            fault_pin_out;
    logic            fault_pin_oe;
    rdsm_reset_src_s reset_src;
    rdsm_faults_s    faults;
    logic            check_start;
    logic            check_done;
    logic            check_fault;
    rdsm_enables_s   enables;
    rdsm_enables_s   en_prev;
    logic            por_n;
    logic            psel;
    logic            penable;
    logic            pwrite;
    logic [11:0]     paddr;
    logic [31:0]     pwdata;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic [7:0]      chk_delay;
    logic            chk_fail;
    int              miscompares;
    int              n_checks;
    int              cyc;
    int              t_exc;
    int              t_loop;
    int              t_mon;

    always #25 clk = ~clk;
    // Open-drain fault wire with its pull-up
    assign fault_pin_in = fault_pin_oe ? fault_pin_out : 1'b1;

    rdsm_state_ctrl #(.DEGLITCH_CYC(DEGLITCH)) rdsm_state_ctrl_i (
        .CLK(clk), .RST(rst), .RESET_PIN_ACTIVE_LOW_N(reset_pin_n),
        .FAULT_CLEAR_PIN(fault_clear), .FAULT_PIN_IN(fault_pin_in),
        .FAULT_PIN_OUT(fault_pin_out), .FAULT_PIN_OE(fault_pin_oe),
        .RESET_SRC(reset_src), .FAULTS(faults), .CHECK_START(check_start),
        .CHECK_DONE(check_done), .CHECK_FAULT(check_fault), .ENABLES(enables),
        .INTERNAL_POWER_ON_RESET_N(por_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr));

    rdsm_check_model rdsm_check_model_i (
        .CLK(clk), .RST(rst), .DELAY(chk_delay), .FAIL(chk_fail),
        .CHECK_START(check_start), .CHECK_DONE(check_done), .CHECK_FAULT(check_fault));

    // Cycle stamps of the exciter, loop and monitor enables' rising edges, for the start-up order
    always @(posedge clk) begin
        cyc <= cyc + 1;
        en_prev <= enables;
        if (enables.exciter && !en_prev.exciter) t_exc <= cyc;
        if (enables.loop && !en_prev.loop) t_loop <= cyc;
        if (enables.monitor && !en_prev.monitor) t_mon <= cyc;
    end

    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        if (n >= 50) chk_bit("pready", 1'b1, pready);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        chk_bit("write error", 1'b0, e);
    endtask

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] m,
                          input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk_word(what, exp, r & m);
    endtask

    // Polls the state field until it shows st, then compares it
    task automatic wait_st(input logic [1:0] st);
        logic [31:0] r;
        logic        e;
        int          n;
        n = 0;
        do begin
            apb(1'b0, `RDSM_STAT_ADDR, 32'h0, r, e);
            n++;
        end while (r[1:0] !== st && n < 60);
        chk_word("state", {30'h0, st}, r & 32'h3);
    endtask

    task automatic wait_por;
        int n;
        n = 0;
        while (por_n !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk_bit("logic released", 1'b1, por_n);
    endtask

    task automatic clear_pulse;
        fault_clear <= 1'b0;
        repeat (5) @(posedge clk);
        fault_clear <= 1'b1;
    endtask

    task automatic chk_order;
        chk_bit("enable order", 1'b1, t_exc < t_loop && t_loop < t_mon);
    endtask

    // Exciter state expected in fault for the single fault bit i
    function automatic logic exc_exp(input int i, input logic [3:0] ov);
        if (i >= 7) return 1'b1;
        if (i == 0) return 1'b0;
        if (i == 6) return ov[0];
        if (i >= 4) return ov[1];
        if (i >= 2) return ov[2];
        return ov[3];
    endfunction

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        miscompares++;
        stop_test;
    end

    initial begin
        logic [31:0] r;
        logic        e;
        logic [3:0]  ov;
        rst <= 1'b1;
        reset_pin_n <= 1'b0;
        fault_clear <= 1'b1;
        reset_src <= '0;
        faults <= '0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 12'h000;
        pwdata <= 32'h0;
        chk_delay <= 8'h00;
        chk_fail <= 1'b1;
        repeat (8) @(posedge clk);
        chk_word("enables in reset", 32'h0, {25'h0, enables});
        chk_bit("pin low in reset", 1'b0, fault_pin_in);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        chk_bit("held by reset pin", 1'b0, por_n);
        reset_pin_n <= 1'b1;
        repeat (DEGLITCH + 3) @(posedge clk);
        chk_bit("held in deglitch", 1'b0, por_n);
        wait_por;
        repeat (2) @(posedge clk);
        chk_word("diag enables", 32'h60, {25'h0, enables & 7'b1111101});
        chk_bit("pin low in diag", 1'b1, fault_pin_oe);
        wait_st(2'd1);
        repeat (30) @(posedge clk);
        rd_chk("locked diag", `RDSM_STAT_ADDR, 32'h1F, 32'h19);
        chk_delay <= 8'd20;
        chk_fail <= 1'b0;
        wr(`RDSM_CTRL_ADDR, 32'h8);
        wait_st(2'd2);
        rd_chk("leave bit clears", `RDSM_CTRL_ADDR, 32'h8, 32'h0);
        repeat (5) @(posedge clk);
        chk_order;
        chk_word("normal enables", 32'h7D, {25'h0, enables & 7'b1111101});
        chk_bit("pin low in normal", 1'b0, fault_pin_in);
        rd_chk("enable readback", `RDSM_CTRL_ADDR, 32'h3, 32'h3);
        wr(`RDSM_CTRL_ADDR, 32'h0);
        repeat (2) @(posedge clk);
        chk_word("manual off", 32'h0, {30'h0, enables.exciter, enables.loop});
        rd_chk("off readback", `RDSM_CTRL_ADDR, 32'h3, 32'h0);
        wr(`RDSM_CTRL_ADDR, 32'h3);
        repeat (4) @(posedge clk);
        chk_word("manual on", 32'h3, {30'h0, enables.exciter, enables.loop});
        wr(`RDSM_CTRL_ADDR, 32'h7);
        wait_st(2'd1);
        chk_word("diag stops", 32'h0, {30'h0, enables.exciter, enables.loop});
        rd_chk("rerun bit clears", `RDSM_CTRL_ADDR, 32'h4, 32'h0);
        wait_st(2'd2);
        repeat (5) @(posedge clk);
        chk_order;
        apb(1'b0, 12'h010, 32'h0, r, e);
        chk_bit("unmapped error", 1'b1, e);
        chk_word("unmapped data", 32'h0, r);
        apb(1'b1, `RDSM_STAT_ADDR, 32'h3, r, e);
        chk_bit("status read only", 1'b1, e);
        for (int j = 0; j < 5; j++) begin
            ov = (j < 4) ? 4'(1 << j) : 4'h0;
            wr(`RDSM_OVR_ADDR, {28'h0, ov});
            rd_chk("override readback", `RDSM_OVR_ADDR, 32'hF, {28'h0, ov});
            for (int i = 0; i < 13; i++) begin
                faults <= rdsm_faults_s'(13'(1 << i));
                repeat (4) @(posedge clk);
                rd_chk("fault state", `RDSM_STAT_ADDR, 32'h3, 32'h3);
                chk_bit("pin released", 1'b0, fault_pin_oe);
                chk_word("loop and data", 32'h0, {30'h0, enables.loop, enables.data_valid});
                chk_bit("exciter", exc_exp(i, ov), enables.exciter);
                rd_chk("fault flags", `RDSM_FLAG_ADDR, 32'h1FFF, 32'(1 << i));
                if (i == 0) begin
                    wr(`RDSM_CTRL_ADDR, 32'h3);
                    chk_bit("exciter blocked", 1'b0, enables.exciter);
                end
                faults <= '0;
                clear_pulse;
                wait_st(2'd2);
                repeat (5) @(posedge clk);
                chk_bit("exciter back", 1'b1, enables.exciter);
            end
        end
        for (int k = 0; k < 4; k++) begin
            reset_src <= rdsm_reset_src_s'(4'(1 << k));
            repeat (4) @(posedge clk);
            chk_bit("reset source", 1'b0, por_n);
            chk_word("blocks off", 32'h0, {25'h0, enables});
            chk_bit("pin low", 1'b1, fault_pin_oe);
            reset_src <= '0;
            wait_por;
            wait_st(2'd1);
            wait_st(2'd2);
        end
        stop_test;
    end
endmodule
